// ===== src/gps_top.sv
// Top of the GPIO block: AHB-Lite register slave and two ports.
`timescale 1ns/100ps
module gps_top (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  // AHB-Lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  input wire logic I_HRMW,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // Standby and reset-pin variant inputs
  input wire logic I_STANDBY_STOP_WATCH,
  input wire logic [1:0] I_EXT_INT_EN,
  input wire logic [1:0] I_EVT_INT_EN,
  input wire logic I_RESET_PIN_VARIANT,
  // Port 6 peripherals and pads
  input wire logic [7:0] I_P6_PER_OE,
  input wire logic [7:0] I_P6_PER_OUT,
  input wire logic [7:0] I_P6_PIN,
  output logic [7:0] O_P6_OUT,
  output logic [7:0] O_P6_OE,
  output logic [7:0] O_P6_PULL,
  output logic [7:0] O_P6_IN,
  // Three-pin port peripherals and pads
  input wire logic [2:0] I_PF_PER_OE,
  input wire logic [2:0] I_PF_PER_OUT,
  input wire logic [2:0] I_PF_PIN,
  output logic [2:0] O_PF_OUT,
  output logic [2:0] O_PF_OE,
  output logic [2:0] O_PF_IN
);

  gps_pkg::gps_aphase_t aph_reg;
  logic [7:0] p6_data_reg;
  logic [7:0] p6_dir_reg;
  logic [7:0] p6_pull_reg;
  logic [2:0] pf_data_reg;
  logic [2:0] pf_dir_reg;
  logic float_sel_reg;
  logic float_act_reg;
  logic float_act_next;
  logic [31:0] rdata_next;
  logic [7:0] p6_sync;
  logic [2:0] pf_sync;
  logic [7:0] p6_keep;
  logic [7:0] p6_in;
  logic [2:0] pf_in;
  logic [2:0] pf_dir_eff;
  logic [2:0] pf_oe_eff;
  logic [2:0] pf_oe_raw;
  gps_pkg::gps_pad_t p6_pad;

  // Any selected active transfer is claimed, whatever its size; idle and busy pass as idle.
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      aph_reg <= '0;
    end else if (I_HREADY) begin
      aph_reg.valid <= I_HSEL & I_HTRANS[1];
      aph_reg.write <= I_HWRITE;
      aph_reg.rmw <= I_HRMW;
      aph_reg.offset <= I_HADDR[7:0];
    end
  end

  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;

  // Register writes land in the data phase.
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      p6_data_reg <= gps_pkg::GPS_RST_P6_DATA;
      p6_dir_reg <= gps_pkg::GPS_RST_P6_DIR;
      p6_pull_reg <= gps_pkg::GPS_RST_P6_PULL;
      pf_data_reg <= gps_pkg::GPS_RST_PF_DATA;
      pf_dir_reg <= gps_pkg::GPS_RST_PF_DIR;
      float_sel_reg <= 1'b0;
    end else if (aph_reg.valid && aph_reg.write) begin
      case (aph_reg.offset)
        gps_pkg::GPS_OFS_P6_DATA: p6_data_reg <= I_HWDATA[7:0];
        gps_pkg::GPS_OFS_P6_DIR: p6_dir_reg <= I_HWDATA[7:0];
        gps_pkg::GPS_OFS_P6_PULL: p6_pull_reg <= I_HWDATA[7:0];
        gps_pkg::GPS_OFS_PF_DATA: pf_data_reg <= I_HWDATA[2:0];
        gps_pkg::GPS_OFS_PF_DIR: pf_dir_reg <= I_HWDATA[2:0];
        gps_pkg::GPS_OFS_STBY: float_sel_reg <= I_HWDATA[gps_pkg::GPS_STBY_FLOAT_BIT];
        default: ;
      endcase
    end
  end

  // In standby the float selection is sampled each cycle until set, then held for the rest of the stay.
  always_comb begin
    float_act_next = float_act_reg;
    if (!I_STANDBY_STOP_WATCH) begin
      float_act_next = 1'b0;
    end else if (!float_act_reg) begin
      float_act_next = float_sel_reg;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      float_act_reg <= 1'b0;
    end else begin
      float_act_reg <= float_act_next;
    end
  end

  gps_sync #(.W(8)) u_sync6 (
    .i_clk(I_REF_CLK),
    .i_srst(I_SRST),
    .i_async(I_P6_PIN),
    .o_sync(p6_sync)
  );

  gps_sync #(.W(3)) u_syncf (
    .i_clk(I_REF_CLK),
    .i_srst(I_SRST),
    .i_async(I_PF_PIN),
    .o_sync(pf_sync)
  );

  always_comb begin
    p6_keep = 8'h00;
    p6_keep[gps_pkg::GPS_PIN_INT8] = I_EXT_INT_EN[0];
    p6_keep[gps_pkg::GPS_PIN_INT9] = I_EXT_INT_EN[1];
    p6_keep[gps_pkg::GPS_PIN_EVCNT] = I_EVT_INT_EN[0];
    p6_keep[gps_pkg::GPS_PIN_TRIG] = I_EVT_INT_EN[1];
  end

  gps_pad_ctl #(.W(8)) u_pad6 (
    .i_latch(p6_data_reg),
    .i_dir(p6_dir_reg),
    .i_pull_en(p6_pull_reg),
    .i_per_oe(I_P6_PER_OE),
    .i_per_out(I_P6_PER_OUT),
    .i_float(float_act_reg),
    .i_in_keep(p6_keep),
    .i_pin_sync(p6_sync),
    .o_out(p6_pad.out),
    .o_oe(p6_pad.oe),
    .o_pull(p6_pad.pull),
    .o_in_level(p6_in)
  );

  // On the reset-pin variant pin 2 is never driven as general-purpose I/O.
  assign pf_dir_eff = {pf_dir_reg[2] & ~I_RESET_PIN_VARIANT, pf_dir_reg[1:0]};

  gps_pad_ctl #(.W(3)) u_padf (
    .i_latch(pf_data_reg),
    .i_dir(pf_dir_eff),
    .i_pull_en(3'h0),
    .i_per_oe(I_PF_PER_OE),
    .i_per_out(I_PF_PER_OUT),
    .i_float(float_act_reg),
    .i_in_keep(3'h0),
    .i_pin_sync(pf_sync),
    .o_out(O_PF_OUT),
    .o_oe(pf_oe_raw),
    .o_pull(),
    .o_in_level(pf_in)
  );

  assign pf_oe_eff = {pf_oe_raw[2] & ~I_RESET_PIN_VARIANT, pf_oe_raw[1:0]};
  assign O_PF_OE = pf_oe_eff;
  assign O_P6_OUT = p6_pad.out;
  assign O_P6_OE = p6_pad.oe;
  assign O_P6_PULL = p6_pad.pull;
  assign O_P6_IN = p6_in;
  assign O_PF_IN = pf_in;

  // Direction-one pins not taken by a peripheral, and RMW reads, return the latch; else the synchronised pin, read low while standby float blocks it.
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (aph_reg.offset)
      gps_pkg::GPS_OFS_P6_DATA: begin
        for (int i = 0; i < 8; i++) begin
          if (aph_reg.rmw || (p6_dir_reg[i] && !I_P6_PER_OE[i])) begin
            rdata_next[i] = p6_data_reg[i];
          end else begin
            rdata_next[i] = p6_in[i];
          end
        end
      end
      gps_pkg::GPS_OFS_P6_DIR: rdata_next[7:0] = p6_dir_reg;
      gps_pkg::GPS_OFS_P6_PULL: rdata_next[7:0] = p6_pull_reg;
      gps_pkg::GPS_OFS_PF_DATA: begin
        for (int i = 0; i < 3; i++) begin
          if (aph_reg.rmw || (pf_dir_eff[i] && !I_PF_PER_OE[i])) begin
            rdata_next[i] = pf_data_reg[i];
          end else begin
            rdata_next[i] = pf_in[i];
          end
        end
      end
      gps_pkg::GPS_OFS_PF_DIR: rdata_next[2:0] = pf_dir_reg;
      gps_pkg::GPS_OFS_STBY: begin
        rdata_next[gps_pkg::GPS_STBY_FLOAT_BIT] = float_sel_reg;
        rdata_next[gps_pkg::GPS_STBY_ACTIVE_BIT] = float_act_reg;
      end
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data is combinational in the data phase so the slave needs no wait state.
  assign O_HRDATA = (aph_reg.valid && !aph_reg.write) ? rdata_next : 32'h0000_0000;

endmodule

// ===== src/gps_pkg.sv
// Package with register map, reset values and carrier types for the GPIO port block.
// How it works
// - Direction one drives latch onto pin.
// - Direction zero leaves pin undriven input.
// - Data write always updates output latch.
// - Output pin reads back latch value.
// - Input pin reads pin; RMW reads latch.
// - Peripheral enable drives peripheral value instead.
// - Peripheral-driven pin reads pin; RMW reads latch.
// - Reset clears port-6 direction to zero.
// - Standby float forces Hi-Z, input held low.
// - Enabled interrupt pins stay unblocked in float.
// - Float bit zero keeps pins unchanged.
// - Pull-up enable bit connects pull-up.
// - Pull-up off while pin drives low.
// - Port-6 bit n maps to pin n.
// - Three-pin port implements only bits 2..0.
// - Pin 2 may be dedicated reset input.
// - Three-pin port uses same direction semantics.
// - Three-pin reads: latch for latch-driven outputs, else pin; latch on RMW.
// - Reset clears three-pin direction to zero.
package gps_pkg;

  localparam logic [7:0] GPS_OFS_P6_DATA = 8'h00;
  localparam logic [7:0] GPS_OFS_P6_DIR = 8'h04;
  localparam logic [7:0] GPS_OFS_P6_PULL = 8'h08;
  localparam logic [7:0] GPS_OFS_PF_DATA = 8'h0C;
  localparam logic [7:0] GPS_OFS_PF_DIR = 8'h10;
  localparam logic [7:0] GPS_OFS_STBY = 8'h14;

  localparam int GPS_P6_W = 8;
  localparam int GPS_PF_W = 3;

  localparam logic [7:0] GPS_RST_P6_DATA = 8'h00;
  localparam logic [7:0] GPS_RST_P6_DIR = 8'h00;
  localparam logic [7:0] GPS_RST_P6_PULL = 8'h00;
  localparam logic [2:0] GPS_RST_PF_DATA = 3'h0;
  localparam logic [2:0] GPS_RST_PF_DIR = 3'h0;

  // Standby control register fields.
  localparam int GPS_STBY_FLOAT_BIT = 0;
  localparam int GPS_STBY_ACTIVE_BIT = 8;

  // Port-6 pins whose input path stays open in standby when their interrupt enable is set.
  localparam int GPS_PIN_INT8 = 0;
  localparam int GPS_PIN_INT9 = 1;
  localparam int GPS_PIN_EVCNT = 4;
  localparam int GPS_PIN_TRIG = 7;

  // Latched AHB address phase.
  typedef struct packed {
    logic valid;
    logic write;
    logic rmw;
    logic [7:0] offset;
  } gps_aphase_t;

  // Per-port pad drive bundle.
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } gps_pad_t;

endpackage

// ===== src/gps_sync.sv
// Two-flop synchroniser for a bank of pin inputs.
`timescale 1ns/100ps
module gps_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule

// ===== src/gps_pad_ctl.sv
// Per-pin pad control: direction, peripheral takeover, standby float and pull-up.
`timescale 1ns/100ps
module gps_pad_ctl #(
  parameter int W = 8
) (
  // Register state
  input wire logic [W-1:0] i_latch,
  input wire logic [W-1:0] i_dir,
  input wire logic [W-1:0] i_pull_en,
  // Peripheral overrides
  input wire logic [W-1:0] i_per_oe,
  input wire logic [W-1:0] i_per_out,
  // Standby
  input wire logic i_float,
  input wire logic [W-1:0] i_in_keep,
  // Synchronised pin levels
  input wire logic [W-1:0] i_pin_sync,
  // Pad outputs
  output logic [W-1:0] o_out,
  output logic [W-1:0] o_oe,
  output logic [W-1:0] o_pull,
  output logic [W-1:0] o_in_level
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      logic drv;
      logic val;
      assign drv = (i_per_oe[g] | i_dir[g]) & ~i_float;
      assign val = i_per_oe[g] ? i_per_out[g] : i_latch[g];
      assign o_out[g] = val;
      assign o_oe[g] = drv;
      assign o_pull[g] = i_pull_en[g] & ~(drv & ~val);
      // Blocked inputs read low so an open pin cannot toggle logic in standby.
      assign o_in_level[g] = i_pin_sync[g] & (~i_float | i_in_keep[g]);
    end
  endgenerate

endmodule

// ===== bench/gps_pin_model.sv
// Pad model: resolves each pin from the block, the outside driver and the pull-up.
`timescale 1ns/100ps
module gps_pin_model #(
  parameter int W = 8
) (
  // Clock
  input wire logic i_clk,
  // Block side
  input wire logic [W-1:0] i_out,
  input wire logic [W-1:0] i_oe,
  input wire logic [W-1:0] i_pull,
  // Outside driver
  input wire logic [W-1:0] i_ext,
  input wire logic [W-1:0] i_ext_en,
  output logic [W-1:0] o_pin
);
  // A pad nobody drives or pulls has no level, so it toggles every cycle.
  logic [W-1:0] flt_reg = '0;
  always_ff @(posedge i_clk) flt_reg <= ~flt_reg;
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext) |
    (~i_oe & ~i_ext_en & (i_pull | flt_reg));
endmodule

// ===== bench/gps_top_sva.sv
// Checker with port-level assertions for the GPIO block.
`timescale 1ns/100ps
module gps_top_sva (
  // Clock, reset and bus
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  input wire logic I_HSEL,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HREADY,
  input wire logic [31:0] O_HRDATA,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  // Standby and pads
  input wire logic I_STANDBY_STOP_WATCH,
  input wire logic I_RESET_PIN_VARIANT,
  input wire logic [7:0] I_P6_PER_OE,
  input wire logic [7:0] I_P6_PER_OUT,
  input wire logic [7:0] I_P6_PIN,
  input wire logic [7:0] O_P6_OUT,
  input wire logic [7:0] O_P6_OE,
  input wire logic [7:0] O_P6_PULL,
  input wire logic [7:0] O_P6_IN,
  input wire logic [2:0] O_PF_OE
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SRST);
  // Counts edges since reset so that history from before the reset is never used.
  logic [1:0] up_reg;
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  a_bus_ready_okay: assert property (O_HREADYOUT && !O_HRESP)
    else $error("bus answer not ready or not okay");
  a_reset_no_drive: assert property (up_reg == 2'h1 |->
    (O_P6_OE & ~I_P6_PER_OE) == 8'h00 && O_PF_OE == 3'h0)
    else $error("pin driven right after reset");
  a_pull_low_off: assert property ((O_P6_PULL & O_P6_OE & ~O_P6_OUT) == 8'h00)
    else $error("pull-up on a pin driving low");
  a_periph_takes_pin: assert property ((!I_STANDBY_STOP_WATCH)[*2] |->
    (O_P6_OE & I_P6_PER_OE) == I_P6_PER_OE &&
    ((O_P6_OUT ^ I_P6_PER_OUT) & I_P6_PER_OE) == 8'h00)
    else $error("peripheral value not on pin");
  a_reset_pin_idle: assert property (I_RESET_PIN_VARIANT |-> !O_PF_OE[2])
    else $error("reset-only pin driven");
  a_rdata_idle_zero: assert property (!$past(I_HSEL && I_HTRANS[1] && I_HREADY) |-> O_HRDATA == 32'h0000_0000)
    else $error("read data outside data phase");
  a_rdata_high_zero: assert property (O_HRDATA[31:9] == 23'h0)
    else $error("read data upper bits set");
  a_pin_sync_two: assert property ((!I_STANDBY_STOP_WATCH)[*3] ##0 up_reg == 2'h3 |->
    O_P6_IN == $past(I_P6_PIN, 2))
    else $error("pin input not two edges late");
  c_periph: cover property (I_P6_PER_OE != 8'h00);
  c_standby: cover property (I_STANDBY_STOP_WATCH);
  c_pull: cover property (O_P6_PULL != 8'h00);
endmodule
bind gps_top gps_top_sva chk_i (.I_REF_CLK(I_REF_CLK), .I_SRST(I_SRST), .I_HSEL(I_HSEL),
  .I_HTRANS(I_HTRANS), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT),
  .O_HRESP(O_HRESP), .I_STANDBY_STOP_WATCH(I_STANDBY_STOP_WATCH),
  .I_RESET_PIN_VARIANT(I_RESET_PIN_VARIANT), .I_P6_PER_OE(I_P6_PER_OE),
  .I_P6_PER_OUT(I_P6_PER_OUT), .I_P6_PIN(I_P6_PIN), .O_P6_OUT(O_P6_OUT), .O_P6_OE(O_P6_OE),
  .O_P6_PULL(O_P6_PULL), .O_P6_IN(O_P6_IN), .O_PF_OE(O_PF_OE));

// ===== bench/tb_gps_top.sv
// Self-checking testbench for the GPIO block.
`timescale 1ns/100ps
module tb_gps_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, hrmw = 1'b0, stby = 1'b0, rvar = 1'b0, hready, hresp;
  logic [1:0] htrans = 2'h0, xint = 2'h0, eint = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic [7:0] poe = 8'h00, pout = 8'h00, p6pin, p6out, p6oe, p6pull, p6in;
  logic [2:0] fpin, fout, foe, fin;
  logic [2:0] hsize = 3'h2, pfoe = 3'h0, pfout = 3'h0, fext = 3'h2;
  logic [7:0] ext6 = 8'hC3;
  int errors = 0;
  int comparisons = 0;
  initial forever #5 clk = ~clk;
  gps_top uut (.I_REF_CLK(clk), .I_SRST(srst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready), .I_HRMW(hrmw),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_STANDBY_STOP_WATCH(stby),
    .I_EXT_INT_EN(xint), .I_EVT_INT_EN(eint), .I_RESET_PIN_VARIANT(rvar), .I_P6_PER_OE(poe),
    .I_P6_PER_OUT(pout), .I_P6_PIN(p6pin), .O_P6_OUT(p6out), .O_P6_OE(p6oe), .O_P6_PULL(p6pull),
    .O_P6_IN(p6in), .I_PF_PER_OE(pfoe), .I_PF_PER_OUT(pfout), .I_PF_PIN(fpin), .O_PF_OUT(fout),
    .O_PF_OE(foe), .O_PF_IN(fin));
  gps_pin_model #(.W(8)) p6_pads (.i_clk(clk), .i_out(p6out), .i_oe(p6oe), .i_pull(p6pull),
    .i_ext(ext6), .i_ext_en(8'hFF), .o_pin(p6pin));
  gps_pin_model #(.W(3)) pf_pads (.i_clk(clk), .i_out(fout), .i_oe(foe), .i_pull(3'h0),
    .i_ext(fext), .i_ext_en(3'h7), .o_pin(fpin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Samples just before each edge, so the value taken is the one that edge sees.
  task automatic edge_rdy();
    int n;
    logic r;
    n = 0;
    do begin
      @(negedge clk);
      r = hready;
      rd = hrdata;
      @(posedge clk);
      n++;
    end while (r !== 1'b1 && n < 20);
    if (r !== 1'b1) begin
      errors++;
      results();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic m);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hsize <= 3'h2;
    hwrite <= w;
    hrmw <= m;
    edge_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
  endtask
  task automatic rdc(input logic [7:0] a, input logic m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, m);
    chk(rd, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdc(8'h04, 1'b0, 32'h0000_0000);
    rdc(8'h10, 1'b0, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_00A5, 1'b0);
    cyc(3);
    chk(32'(p6oe), 32'h0000_0000);
    rdc(8'h00, 1'b0, 32'h0000_00C3);
    rdc(8'h00, 1'b1, 32'h0000_00A5);
    bus(1'b1, 8'h04, 32'h0000_00F0, 1'b0);
    cyc(3);
    chk(32'({p6oe, p6out & p6oe}), 32'h0000_F0A0);
    rdc(8'h00, 1'b0, 32'h0000_00A3);
    bus(1'b1, 8'h08, 32'h0000_00FF, 1'b0);
    cyc(1);
    chk(32'(p6pull), 32'h0000_00AF);
    poe <= 8'h0C;
    pout <= 8'h04;
    cyc(3);
    chk(32'({p6oe & 8'h0C, p6out & 8'h0C}), 32'h0000_0C04);
    rdc(8'h00, 1'b0, 32'h0000_00A7);
    rdc(8'h00, 1'b1, 32'h0000_00A5);
    poe <= 8'h00;
    bus(1'b1, 8'h10, 32'h0000_00FF, 1'b0);
    rdc(8'h10, 1'b0, 32'h0000_0007);
    bus(1'b1, 8'h0C, 32'h0000_0005, 1'b0);
    cyc(1);
    chk(32'({foe, fout}), 32'h0000_003D);
    rvar <= 1'b1;
    cyc(1);
    chk(32'(foe), 32'h0000_0003);
    rvar <= 1'b0;
    bus(1'b1, 8'h10, 32'h0000_0001, 1'b0);
    cyc(3);
    rdc(8'h0C, 1'b0, 32'h0000_0003);
    rdc(8'h0C, 1'b1, 32'h0000_0005);
    pfoe <= 3'h2;
    pfout <= 3'h0;
    cyc(3);
    chk(32'({foe, fout}), 32'h0000_001D);
    rdc(8'h0C, 1'b0, 32'h0000_0001);
    pfoe <= 3'h0;
    rdc(8'h40, 1'b0, 32'h0000_0000);
    bus(1'b1, 8'h14, 32'h0000_0001, 1'b0);
    xint <= 2'h1;
    eint <= 2'h2;
    stby <= 1'b1;
    cyc(4);
    chk(32'({p6oe, 5'h00, foe}), 32'h0000_0000);
    chk(32'(p6in), 32'h0000_0081);
    chk(32'(fin), 32'h0000_0000);
    rdc(8'h14, 1'b0, 32'h0000_0101);
    stby <= 1'b0;
    bus(1'b1, 8'h14, 32'h0000_0000, 1'b0);
    stby <= 1'b1;
    cyc(3);
    chk(32'({p6oe, p6out & p6oe}), 32'h0000_F0A0);
    stby <= 1'b0;
    bus(1'b1, 8'h04, 32'h0000_0000, 1'b0);
    ext6 <= 8'h3C;
    cyc(3);
    rdc(8'h00, 1'b0, 32'h0000_003C);
    chk(32'(p6in), 32'h0000_003C);
    rdc(8'h00, 1'b1, 32'h0000_00A5);
    bus(1'b1, 8'h04, 32'h0000_00FF, 1'b0);
    srst <= 1'b1;
    cyc(2);
    srst <= 1'b0;
    @(posedge clk);
    rdc(8'h04, 1'b0, 32'h0000_0000);
    results();
  end
endmodule
